/* bench/cacm_checker.sv */
/*
  Port checker for cacm_top, bound after the module.
  Assumes one clk_sys domain and an active-low rst_b.
*/
module cacm_checker (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        cpu_idle,
  input wire logic [2:0]  module_event,
  input wire logic [2:0]  module_irq_enable,
  input wire logic        watchdog_match,
  input wire logic [15:0] counter_value,
  input wire logic        counter_array_irq,
  input wire logic        watchdog_enable,
  input wire logic        watchdog_reset
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  logic mode_wr;
  assign mode_wr = sfr_wr && sfr_addr == 8'hD9;
  sequence s_mod_evt;
    module_event[0] && module_irq_enable[0] && !cpu_idle
      ##1 module_irq_enable[0];
  endsequence
  property p_irq_mod;
    s_mod_evt |=> counter_array_irq;
  endproperty
  a_irq_mod: assert property (p_irq_mod)
    else $error("module event raised no interrupt");
  property p_cnt_step;
    !$stable(counter_value) |->
      counter_value == $past(counter_value) + 16'h1;
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("counter did not step by one");
  property p_wde_fall;
    $fell(watchdog_enable) |->
      $past(mode_wr && !sfr_wdata[6] && !sfr_wdata[5]);
  endproperty
  a_wde_fall: assert property (p_wde_fall)
    else $error("watchdog dropped without a clearing write");
  property p_wde_rise;
    $rose(watchdog_enable) |->
      $past(mode_wr && (sfr_wdata[6] || sfr_wdata[5]));
  endproperty
  a_wde_rise: assert property (p_wde_rise)
    else $error("watchdog rose without a write");
  property p_wdr_force;
    sfr_wr && sfr_addr == 8'hD8 && sfr_wdata[2] && watchdog_enable
      |=> watchdog_reset;
  endproperty
  a_wdr_force: assert property (p_wdr_force)
    else $error("flag write gave no watchdog reset");
  property p_wdr_match;
    watchdog_match && watchdog_enable && !cpu_idle |=> watchdog_reset;
  endproperty
  a_wdr_match: assert property (p_wdr_match)
    else $error("match gave no watchdog reset");
  property p_wdr_cause;
    watchdog_reset |-> $past(watchdog_enable);
  endproperty
  a_wdr_cause: assert property (p_wdr_cause)
    else $error("watchdog reset while disabled");
  property p_rd_hold;
    !$past(sfr_rd) |-> $stable(sfr_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  property p_rd_unmapped;
    sfr_rd && sfr_addr != 8'hD8 && sfr_addr != 8'hD9
      |=> sfr_rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
endmodule : cacm_checker

bind cacm_top cacm_checker u_cacm_checker (
  .clk_sys(clk_sys), .rst_b(rst_b), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle),
  .module_event(module_event), .module_irq_enable(module_irq_enable),
  .watchdog_match(watchdog_match), .counter_value(counter_value),
  .counter_array_irq(counter_array_irq),
  .watchdog_enable(watchdog_enable), .watchdog_reset(watchdog_reset)
);

/* bench/counter_array_control_mode_test.sv */
/*
  Self-checking testbench for cacm_top.
  Assumes a 200 MHz clk_sys and the checker bound in its own file.
*/
module counter_array_control_mode_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_rdata;
  logic        cpu_idle = 1'b0;
  logic [2:0]  module_event = 3'h0;
  logic [2:0]  module_irq_enable = 3'h0;
  logic        watchdog_match = 1'b0;
  logic        timer0_overflow = 1'b0;
  logic        external_count_input = 1'b1;
  logic        ext_osc_clk = 1'b0;
  logic        rtc_osc_clk = 1'b0;
  logic [15:0] counter_value;
  logic        count_tick;
  logic        irq;
  logic        watchdog_enable;
  logic        watchdog_reset;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n_wdr = 0;

  always #2.5 clk_sys = ~clk_sys;

  cacm_top u_cacm_top (
    .clk_sys(clk_sys), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle),
    .module_event(module_event), .module_irq_enable(module_irq_enable),
    .watchdog_match(watchdog_match), .timer0_overflow(timer0_overflow),
    .external_count_input(external_count_input), .ext_osc_clk(ext_osc_clk),
    .rtc_osc_clk(rtc_osc_clk), .counter_value(counter_value),
    .count_tick(count_tick), .counter_array_irq(irq),
    .watchdog_enable(watchdog_enable), .watchdog_reset(watchdog_reset)
  );

  // Free-running count sources
  always @(negedge clk_sys)
  begin
    cyc <= cyc + 1;
    timer0_overflow <= (cyc % 5 == 0);
    if (cyc % 4 == 0)
      external_count_input <= ~external_count_input;
    if (cyc % 3 == 0)
      ext_osc_clk <= ~ext_osc_clk;
    if (cyc % 5 == 0)
      rtc_osc_clk <= ~rtc_osc_clk;
  end

  always @(negedge clk_sys)
    if (watchdog_reset === 1'b1)
      n_wdr <= n_wdr + 1;

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    chk({8'h00, sfr_rdata}, {8'h00, e});
  endtask : rchk

  // Cycles between two counter steps, 0 if none
  task automatic gap(output int g);
    logic [15:0] v;
    int          n;
    n = 0;
    g = 0;
    v = counter_value;
    repeat (400)
    begin
      @(negedge clk_sys);
      if (counter_value !== v)
      begin
        if (n > 0 && g == 0)
          g = n;
        n = 1;
        v = counter_value;
      end
      else if (n > 0)
        n++;
    end
  endtask : gap

  task automatic reset_dut;
    rst_b = 1'b0;
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
  endtask : reset_dut

  task automatic t_wdog;
    int n;
    chk(watchdog_enable, 1'b1);
    rchk(8'hD8, 8'h00);
    rchk(8'hD9, 8'h40);
    rchk(8'hDA, 8'h00);
    wr(8'hD9, 8'hCF);
    rchk(8'hD9, 8'h41);
    n = n_wdr;
    wr(8'hD8, 8'h04);
    @(negedge clk_sys);
    chk(16'(n_wdr - n), 16'h1);
    watchdog_match = 1'b1;
    @(negedge clk_sys);
    watchdog_match = 1'b0;
    @(negedge clk_sys);
    chk(16'(n_wdr - n), 16'h2);
    wr(8'hD8, 8'h00);
    wr(8'hD9, 8'h20);
    rchk(8'hD9, 8'h60);
    wr(8'hD9, 8'h00);
    rchk(8'hD9, 8'h60);
    chk(watchdog_enable, 1'b1);
    $display("test watchdog done");
  endtask : t_wdog

  task automatic t_flags;
    int g;
    rchk(8'hD9, 8'h40);
    wr(8'hD9, 8'h00);
    chk(watchdog_enable, 1'b0);
    wr(8'hD9, 8'h08);
    rchk(8'hD9, 8'h08);
    for (int i = 0; i < 3; i++)
    begin
      module_irq_enable = 3'h1 << i;
      module_event[i] = 1'b1;
      @(negedge clk_sys);
      module_event = 3'h0;
      repeat (8) @(negedge clk_sys);
      rchk(8'hD8, 8'h01 << i);
      chk(irq, 1'b1);
      wr(8'hD8, 8'h00);
      @(negedge clk_sys);
      chk(irq, 1'b0);
    end
    module_irq_enable = 3'h0;
    wr(8'hD8, 8'h80);
    repeat (2) @(negedge clk_sys);
    chk(irq, 1'b0);
    wr(8'hD9, 8'h09);
    @(negedge clk_sys);
    chk(irq, 1'b1);
    wr(8'hD8, 8'h00);
    wr(8'hD9, 8'h88);
    wr(8'hD8, 8'h40);
    cpu_idle = 1'b1;
    gap(g);
    chk(16'(g), 16'h0);
    chk(count_tick, 1'b0);
    cpu_idle = 1'b0;
    gap(g);
    chk(16'(g), 16'h1);
    chk(count_tick, 1'b1);
    $display("test flags done");
  endtask : t_flags

  task automatic t_tb;
    int e[8] = '{12, 4, 5, 8, 1, 48, 80, 0};
    int g;
    wr(8'hD9, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'hD9, {4'h0, 3'(c), 1'b0});
      gap(g);
      chk(16'(g), 16'(e[c]));
    end
    wr(8'hD9, 8'h08);
    wr(8'hD8, 8'h00);
    gap(g);
    chk(16'(g), 16'h0);
    chk(count_tick, 1'b0);
    $display("test timebase done");
  endtask : t_tb

  task automatic t_wrap;
    wr(8'hD9, 8'h09);
    wr(8'hD8, 8'h40);
    for (int i = 0; i < 70000 && counter_value !== 16'hFFFF; i++)
      @(negedge clk_sys);
    repeat (3) @(negedge clk_sys);
    rchk(8'hD8, 8'hC0);
    chk(irq, 1'b1);
    wr(8'hD8, 8'h40);
    @(negedge clk_sys);
    chk(irq, 1'b0);
    wr(8'hD9, 8'h40);
    chk(watchdog_enable, 1'b1);
    $display("test wrap done");
  endtask : t_wrap

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    reset_dut();
    t_wdog();
    reset_dut();
    t_flags();
    t_tb();
    t_wrap();
    give_verdict();
  end
endmodule : counter_array_control_mode_test

/* core/cacm_divider.sv */
/*
  Divide-by-N enable generator: one-cycle pulse every N enabled ticks.
  Assumes a single clock domain; tick is a same-clock enable.
*/
module cacm_divider #(
  parameter int unsigned DIV = 12
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic tick,
  output logic      pulse
);
  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
  logic [W-1:0] count;

  // Refuse a divide below two
  if (DIV < 2)
  begin : g_div_check
    $error("cacm_divider: DIV must be at least 2");
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count <= '0;
      pulse <= 1'b0;
    end
    else
    begin
      pulse <= 1'b0;
      if (tick)
      begin
        if (count == W'(DIV - 1))
        begin
          count <= '0;
          pulse <= 1'b1;
        end
        else
          count <= count + 1'b1;
      end
    end
  end
endmodule : cacm_divider

/* core/cacm_sync.sv */
/*
  Two-flop synchroniser with falling-edge detect after the second flop.
  Assumes the input is asynchronous to clk_sys.
*/
module cacm_sync (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      level,
  output logic      fall
);
  logic meta;
  logic last;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta  <= 1'b1;
      level <= 1'b1;
      last  <= 1'b1;
    end
    else
    begin
      meta  <= async_in;
      level <= meta;
      last  <= level;
    end
  end

  assign fall = last & ~level;
endmodule : cacm_sync

/* core/cacm_top.sv */
/*
  Counter array control and mode registers with the 16-bit counter,
  timebase selection, wrap and module flags, interrupt request and
  watchdog enable/lock.
  Assumes a byte-wide special-function-register bus on clk_sys, module
  event pulses and a watchdog match from the compare datapath, and
  timer 0 overflow as a same-clock pulse.
*/
module cacm_top (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       cpu_idle,
  input  wire logic [2:0] module_event,
  input  wire logic [2:0] module_irq_enable,
  input  wire logic       watchdog_match,
  input  wire logic       timer0_overflow,
  input  wire logic       external_count_input,
  input  wire logic       ext_osc_clk,
  input  wire logic       rtc_osc_clk,
  output logic     [15:0] counter_value,
  output logic            count_tick,
  output logic            counter_array_irq,
  output logic            watchdog_enable,
  output logic            watchdog_reset
);
`include "cacm_params.svh"

  logic                   count_wrap_flag;
  logic                   count_run;
  logic [2:0]             module_flags;
  logic                   idle_suspend;
  logic                   watchdog_lock;
  cacm_pkg::cacm_timebase_e timebase_select;
  logic                   wrap_irq_enable;
  logic [15:0]            counter;

  logic                   wr_ctl;
  logic                   wr_md;
  logic                   active;
  logic                   running;
  logic                   tick;
  logic                   wrap;
  logic                   pulse12;
  logic                   pulse4;
  logic                   pulse_ext;
  logic                   pulse_rtc;
  logic                   ext_fall;
  logic                   ext_osc_rise;
  logic                   rtc_rise;
  logic                   ext_osc_lvl;
  logic                   rtc_lvl;
  logic                   ext_osc_last;
  logic                   rtc_last;
  logic [2:0]             next_module_flags;
  logic                   next_wrap_flag;

  function automatic logic flag_next(
    input logic cur,
    input logic hw_set,
    input logic wr,
    input logic wbit
  );
    logic nxt;
    nxt = cur;
    if (wr)
      nxt = wbit;
    if (hw_set)
      nxt = 1'b1;
    return nxt;
  endfunction : flag_next

  // Register write decode
  assign wr_ctl = sfr_wr && (sfr_addr == `CACM_CONTROL_ADDR);
  assign wr_md  = sfr_wr && (sfr_addr == `CACM_MODE_ADDR);

  // Suspended during idle when requested
  assign active  = !(idle_suspend && cpu_idle);
  // Watchdog forces the counter on
  assign running = (count_run || watchdog_enable) && active;

  cacm_divider #(.DIV(`CACM_DIV12)) u_div12 (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tick    (active),
    .pulse   (pulse12)
  );

  cacm_divider #(.DIV(`CACM_DIV4)) u_div4 (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tick    (active),
    .pulse   (pulse4)
  );

  cacm_sync u_sync_eci (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (external_count_input),
    .level    (),
    .fall     (ext_fall)
  );

  cacm_sync u_sync_ext (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (ext_osc_clk),
    .level    (ext_osc_lvl),
    .fall     ()
  );

  cacm_sync u_sync_rtc (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (rtc_osc_clk),
    .level    (rtc_lvl),
    .fall     ()
  );

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_osc_last <= 1'b1;
      rtc_last     <= 1'b1;
    end
    else
    begin
      ext_osc_last <= ext_osc_lvl;
      rtc_last     <= rtc_lvl;
    end
  end

  // Oscillators counted on rising edges
  assign ext_osc_rise = ext_osc_lvl & ~ext_osc_last;
  assign rtc_rise     = rtc_lvl & ~rtc_last;

  cacm_divider #(.DIV(`CACM_DIV8)) u_div_ext (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tick    (ext_osc_rise && active),
    .pulse   (pulse_ext)
  );

  cacm_divider #(.DIV(`CACM_DIV8)) u_div_rtc (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tick    (rtc_rise && active),
    .pulse   (pulse_rtc)
  );

  always_comb
  begin
    unique case (timebase_select)
      cacm_pkg::CACM_TB_DIV12:    tick = pulse12;
      cacm_pkg::CACM_TB_DIV4:     tick = pulse4;
      cacm_pkg::CACM_TB_TMR0:     tick = timer0_overflow;
      cacm_pkg::CACM_TB_EXT_IN:   tick = ext_fall;
      cacm_pkg::CACM_TB_SYSCLK:   tick = 1'b1;
      cacm_pkg::CACM_TB_EXT_CLK:  tick = pulse_ext;
      cacm_pkg::CACM_TB_RTC:      tick = pulse_rtc;
      cacm_pkg::CACM_TB_RESERVED: tick = 1'b0;
    endcase
  end

  assign wrap = running && tick && (counter == 16'hFFFF);

  // Counter
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      counter    <= 16'h0000;
      count_tick <= 1'b0;
    end
    else
    begin
      count_tick <= running && tick;
      if (running && tick)
        counter <= counter + 16'h0001;
    end
  end

  assign counter_value = counter;

  // Flags: hardware set wins over firmware clear
  always_comb
  begin
    next_wrap_flag = flag_next(count_wrap_flag, wrap, wr_ctl,
                               sfr_wdata[`CACM_CTL_WRAP]);
    for (int i = 0; i < 3; i++)
      next_module_flags[i] = flag_next(module_flags[i],
                                       module_event[i] && active,
                                       wr_ctl,
                                       sfr_wdata[i]);
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_wrap_flag <= 1'b0;
      module_flags    <= 3'h0;
      count_run       <= 1'b0;
    end
    else
    begin
      count_wrap_flag <= next_wrap_flag;
      module_flags    <= next_module_flags;
      if (wr_ctl)
        count_run <= sfr_wdata[`CACM_CTL_RUN];
    end
  end

  // Mode register
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idle_suspend    <= 1'b0;
      watchdog_enable <= 1'b1;
      watchdog_lock   <= 1'b0;
      timebase_select <= cacm_pkg::CACM_TB_DIV12;
      wrap_irq_enable <= 1'b0;
    end
    else if (wr_md)
    begin
      wrap_irq_enable <= sfr_wdata[`CACM_MD_WRAP_IE];
      if (!watchdog_enable)
      begin
        idle_suspend    <= sfr_wdata[`CACM_MD_IDLE];
        timebase_select <= cacm_pkg::cacm_timebase_e'(
          sfr_wdata[`CACM_MD_TB_HI:`CACM_MD_TB_LO]);
      end
      if (sfr_wdata[`CACM_MD_LOCK])
      begin
        watchdog_lock   <= 1'b1;
        watchdog_enable <= 1'b1;
      end
      else if (!watchdog_lock)
        watchdog_enable <= sfr_wdata[`CACM_MD_WDE];
    end
  end

  // Interrupt and watchdog reset
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      counter_array_irq <= 1'b0;
      watchdog_reset    <= 1'b0;
    end
    else
    begin
      counter_array_irq <= (count_wrap_flag && wrap_irq_enable)
        || |(module_flags & module_irq_enable);
      watchdog_reset <= watchdog_enable &&
        ((watchdog_match && active)
         || (wr_ctl && sfr_wdata[`CACM_CTL_M2]));
    end
  end

  // Read data, run bit reads as firmware wrote it
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
    begin
      if (sfr_addr == `CACM_CONTROL_ADDR)
        sfr_rdata <= {count_wrap_flag, count_run, 3'h0, module_flags};
      else if (sfr_addr == `CACM_MODE_ADDR)
        sfr_rdata <= {idle_suspend, watchdog_enable, watchdog_lock, 1'b0,
                      timebase_select, wrap_irq_enable};
      else
        sfr_rdata <= 8'h00;
    end
  end
endmodule : cacm_top

/* pkg/cacm_params.svh */
/*
  Register offsets, field positions, reset values and divider ratios
  for the counter array control and mode registers.
  Assumes inclusion by bare name from design files.
*/
`ifndef CACM_PARAMS_SVH
`define CACM_PARAMS_SVH

`define CACM_CONTROL_ADDR    8'hD8
`define CACM_MODE_ADDR       8'hD9
`define CACM_CONTROL_RESET   8'h00
`define CACM_MODE_RESET      8'h40

`define CACM_CTL_WRAP        7
`define CACM_CTL_RUN         6
`define CACM_CTL_M2          2
`define CACM_CTL_M1          1
`define CACM_CTL_M0          0

`define CACM_MD_IDLE         7
`define CACM_MD_WDE          6
`define CACM_MD_LOCK         5
`define CACM_MD_TB_HI        3
`define CACM_MD_TB_LO        1
`define CACM_MD_WRAP_IE      0

`define CACM_DIV12           4'hC
`define CACM_DIV4            4'h4
`define CACM_DIV8            4'h8

`endif

/* pkg/cacm_pkg.sv */
/*
  Types for the counter array control and mode block.
  Assumes cacm_params.svh supplies the numeric constants.
*/
package cacm_pkg;
  typedef enum logic [2:0]
  {
    CACM_TB_DIV12    = 3'h0,
    CACM_TB_DIV4     = 3'h1,
    CACM_TB_TMR0     = 3'h2,
    CACM_TB_EXT_IN   = 3'h3,
    CACM_TB_SYSCLK   = 3'h4,
    CACM_TB_EXT_CLK  = 3'h5,
    CACM_TB_RTC     = 3'h6,
    CACM_TB_RESERVED = 3'h7
  } cacm_timebase_e;
endpackage : cacm_pkg
